//--- shared/tpo_defines.vh
/*
 * Constants of the timed pattern output register block: register
 * indices, reset values, field positions and bus widths.
 * Assumes the includer uses the byte address index*4 on the bus.
 */
`ifndef TPO_DEFINES_VH
`define TPO_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define TPO_IDX_TRIG_SEL       16'hFFA1
`define TPO_IDX_EN_HIGH        16'hFFA2
`define TPO_IDX_EN_LOW         16'hFFA3
`define TPO_IDX_NEXT_HIGH      16'hFFA4
`define TPO_IDX_NEXT_LOW       16'hFFA5
`define TPO_IDX_NEXT_HIGH_ALT  16'hFFA6
`define TPO_IDX_NEXT_LOW_ALT   16'hFFA7
`define TPO_IDX_PA_DIR         16'hFFD1
`define TPO_IDX_PA_DATA        16'hFFD3
`define TPO_IDX_PB_DIR         16'hFFD4
`define TPO_IDX_PB_DATA        16'hFFD6

// ==========================================================
// Reset and read values
// ==========================================================
`define TPO_RST_TRIG_SEL       8'hFF
`define TPO_RST_ZERO           8'h00
`define TPO_RST_NIBBLE         4'h0
`define TPO_RESERVED_ONES      8'hFF
`define TPO_WO_READ            8'h00
`define TPO_UNMAPPED_READ      32'h0000_0000

// ==========================================================
// Trigger select fields
// ==========================================================
`define TPO_SEL_G0_LSB         0
`define TPO_SEL_G1_LSB         2
`define TPO_SEL_G2_LSB         4
`define TPO_SEL_G3_LSB         6

// ==========================================================
// Widths
// ==========================================================
`define TPO_ADR_W              18
`define TPO_NUM_CMP            4

`endif

//--- src/tpo_group.v
/*
 * One 4-bit pattern group: holds the port data nibble, loads the
 * buffered next nibble on the selected compare match, else takes
 * software writes on the bits that pattern output does not own.
 * Assumes compare-match pulses come from logic on clk_i.
 */
`include "tpo_defines.vh"

module tpo_group (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [1:0] trig_sel_i,
  input  wire [3:0] cmp_match_i,
  input  wire [3:0] enable_i,
  input  wire [3:0] next_data_i,
  input  wire       wr_i,
  input  wire [3:0] wr_data_i,
  output reg  [3:0] data_o
);

  // ==========================================================
  // Transfer and write
  // ==========================================================
  wire       trig;
  reg  [3:0] next_data;
  integer    i;

  assign trig = cmp_match_i[trig_sel_i];

  always @* begin
    next_data = data_o;
    for (i = 0; i < 4; i = i + 1) begin
      if (enable_i[i]) begin
        if (trig) begin
          next_data[i] = next_data_i[i];
        end
      end else if (wr_i) begin
        next_data[i] = wr_data_i[i];  // Owned bits ignore writes
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= `TPO_RST_NIBBLE;
    end else begin
      data_o <= next_data;
    end
  end

endmodule // tpo_group

//--- src/tpo_regs.v
/*
 * Register side of the timed pattern output unit: port direction and
 * data registers, next-data buffers with trigger-dependent layout,
 * enable and trigger select registers, reached over classic Wishbone.
 * Assumes compare-match pulses are one clk_i cycle wide and come from
 * the timer on the same clock; hardware standby arrives on a pin.
 */
// Added by the designer: the Wishbone register port.
// Functional notes
// - Port A direction, write-only, reset zero
// - Port B direction register, write-only
// - Port A data register, resets to zero
// - Enabled port A bits ignore writes
// - Port B data register holds group 2
// - Enabled port B bits ignore writes; code does so for bits 3:0 only, bits 7:4 always take writes
// - Next data buffer for groups 0, 1
// - Compare match copies next nibble to port
// - Buffer cleared by reset and hardware standby
// - Buffer kept through software standby
// - Shared trigger: whole buffer at lower address
// - Shared trigger: upper address reads ones
// - Split trigger: group 1 low, group 0 high
// - Split trigger: unused nibbles reserved, read one
// - Transfer only for enabled bits
// - Two-bit select picks channel, resets three
`include "tpo_defines.vh"

module tpo_regs #(
  parameter ADR_W = `TPO_ADR_W
) (
  input  wire             clk_i,
  input  wire             rst_i,
  // Wishbone slave
  input  wire [ADR_W-1:0] adr_i,
  input  wire [31:0]      dat_i,
  input  wire [3:0]       sel_i,
  input  wire             we_i,
  input  wire             cyc_i,
  input  wire             stb_i,
  output reg  [31:0]      dat_o,
  output reg              ack_o,
  // Timer compare-match pulses, channel 0 to 3
  input  wire [3:0]       cmp_match_i,
  // Hardware standby request pin
  input  wire             hw_standby_i,
  // Port pins
  output reg  [7:0]       port_a_out_o,
  output reg  [7:0]       port_a_oe_o,
  output reg  [7:0]       port_b_out_o,
  output reg  [7:0]       port_b_oe_o
);

  // ==========================================================
  // Hardware standby synchroniser
  // ==========================================================
  reg  hw_standby_meta;
  reg  hw_standby_sync;
  wire init;

  always @(posedge clk_i) begin
    if (rst_i) begin
      hw_standby_meta <= 1'b0;
      hw_standby_sync <= 1'b0;
    end else begin
      hw_standby_meta <= hw_standby_i;
      hw_standby_sync <= hw_standby_meta;
    end
  end

  // Standby acts as a held reset; software standby has no input at all,
  // so every register simply keeps its value through it
  assign init = rst_i | hw_standby_sync;

  // ==========================================================
  // Functions
  // ==========================================================
  function hit;
    input [ADR_W-1:0] adr;
    input [15:0]      idx;
    begin
      hit = (adr[ADR_W-1:2] == idx[ADR_W-3:0]);
    end
  endfunction

  // Writable bits of a next-data byte at its lower or upper address
  function [7:0] next_wr_mask;
    input same;
    input upper;
    begin
      if (upper) begin
        next_wr_mask = same ? 8'h00 : 8'h0F;
      end else begin
        next_wr_mask = same ? 8'hFF : 8'hF0;
      end
    end
  endfunction

  // Read view of a next-data byte; reserved bits read as one
  function [7:0] next_rd_view;
    input [7:0] val;
    input       same;
    input       upper;
    begin
      if (upper) begin
        next_rd_view = same ? `TPO_RESERVED_ONES : {4'hF, val[3:0]};
      end else begin
        next_rd_view = same ? val : {val[7:4], 4'hF};
      end
    end
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  reg  [7:0] pattern_trigger_select;
  reg  [7:0] pattern_enable_low_groups;
  reg  [7:0] pattern_enable_high_groups;
  reg  [7:0] next_pattern_low_groups;
  reg  [7:0] next_pattern_high_groups;
  reg  [7:0] port_a_direction;
  reg  [7:0] port_b_direction;
  reg  [3:0] port_b_upper;
  wire [3:0] grp0_data;
  wire [3:0] grp1_data;
  wire [3:0] grp2_data;
  wire [7:0] port_a_output_data;
  wire [7:0] port_b_output_data;

  assign port_a_output_data = {grp1_data, grp0_data};
  assign port_b_output_data = {port_b_upper, grp2_data};

  // Decoding follows the select fields in the same cycle they change
  wire same_low;
  wire same_high;

  assign same_low  = pattern_trigger_select[`TPO_SEL_G0_LSB +: 2] ==
                     pattern_trigger_select[`TPO_SEL_G1_LSB +: 2];
  assign same_high = pattern_trigger_select[`TPO_SEL_G2_LSB +: 2] ==
                     pattern_trigger_select[`TPO_SEL_G3_LSB +: 2];

  // ==========================================================
  // Bus decode
  // ==========================================================
  wire       req;
  wire       wr_en;
  wire [7:0] wd;
  wire       wr_trig_sel;
  wire       wr_en_high;
  wire       wr_en_low;
  wire       wr_next_high;
  wire       wr_next_low;
  wire       wr_next_high_alt;
  wire       wr_next_low_alt;
  wire       wr_pa_dir;
  wire       wr_pa_data;
  wire       wr_pb_dir;
  wire       wr_pb_data;

  assign req   = cyc_i & stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_en = req & we_i & ack_o & sel_i[0];
  assign wd    = dat_i[7:0];

  assign wr_trig_sel      = wr_en & hit(adr_i, `TPO_IDX_TRIG_SEL);
  assign wr_en_high       = wr_en & hit(adr_i, `TPO_IDX_EN_HIGH);
  assign wr_en_low        = wr_en & hit(adr_i, `TPO_IDX_EN_LOW);
  assign wr_next_high     = wr_en & hit(adr_i, `TPO_IDX_NEXT_HIGH);
  assign wr_next_low      = wr_en & hit(adr_i, `TPO_IDX_NEXT_LOW);
  assign wr_next_high_alt = wr_en & hit(adr_i, `TPO_IDX_NEXT_HIGH_ALT);
  assign wr_next_low_alt  = wr_en & hit(adr_i, `TPO_IDX_NEXT_LOW_ALT);
  assign wr_pa_dir        = wr_en & hit(adr_i, `TPO_IDX_PA_DIR);
  assign wr_pa_data       = wr_en & hit(adr_i, `TPO_IDX_PA_DATA);
  assign wr_pb_dir        = wr_en & hit(adr_i, `TPO_IDX_PB_DIR);
  assign wr_pb_data       = wr_en & hit(adr_i, `TPO_IDX_PB_DATA);

  // ==========================================================
  // Control registers
  // ==========================================================
  always @(posedge clk_i) begin
    if (init) begin
      pattern_trigger_select     <= `TPO_RST_TRIG_SEL;
      pattern_enable_low_groups  <= `TPO_RST_ZERO;
      pattern_enable_high_groups <= `TPO_RST_ZERO;
      port_a_direction           <= `TPO_RST_ZERO;
      port_b_direction           <= `TPO_RST_ZERO;
      port_b_upper               <= `TPO_RST_NIBBLE;
    end else begin
      if (wr_trig_sel) begin
        pattern_trigger_select <= wd;
      end
      if (wr_en_low) begin
        pattern_enable_low_groups <= wd;
      end
      if (wr_en_high) begin
        pattern_enable_high_groups <= wd;
      end
      if (wr_pa_dir) begin
        port_a_direction <= wd;
      end
      if (wr_pb_dir) begin
        port_b_direction <= wd;
      end
      if (wr_pb_data) begin
        port_b_upper <= wd[7:4];
      end
    end
  end

  // ==========================================================
  // Next-data buffers
  // ==========================================================
  reg [7:0] next_low;
  reg [7:0] next_high;
  reg [7:0] m;

  always @* begin
    next_low  = next_pattern_low_groups;
    next_high = next_pattern_high_groups;
    m         = 8'h00;
    if (wr_next_low) begin
      m        = next_wr_mask(same_low, 1'b0);
      next_low = (next_low & ~m) | (wd & m);
    end else if (wr_next_low_alt) begin
      m        = next_wr_mask(same_low, 1'b1);
      next_low = (next_low & ~m) | (wd & m);
    end
    if (wr_next_high) begin
      m         = next_wr_mask(same_high, 1'b0);
      next_high = (next_high & ~m) | (wd & m);
    end else if (wr_next_high_alt) begin
      m         = next_wr_mask(same_high, 1'b1);
      next_high = (next_high & ~m) | (wd & m);
    end
  end

  always @(posedge clk_i) begin
    if (init) begin
      next_pattern_low_groups  <= `TPO_RST_ZERO;
      next_pattern_high_groups <= `TPO_RST_ZERO;
    end else begin
      next_pattern_low_groups  <= next_low;
      next_pattern_high_groups <= next_high;
    end
  end

  // ==========================================================
  // Pattern groups
  // ==========================================================
  // A group samples the buffer as it stood before a same-cycle write
  tpo_group u_grp0 (
    .clk_i       (clk_i),
    .rst_i       (init),
    .trig_sel_i  (pattern_trigger_select[`TPO_SEL_G0_LSB +: 2]),
    .cmp_match_i (cmp_match_i),
    .enable_i    (pattern_enable_low_groups[3:0]),
    .next_data_i (next_pattern_low_groups[3:0]),
    .wr_i        (wr_pa_data),
    .wr_data_i   (wd[3:0]),
    .data_o      (grp0_data)
  );

  tpo_group u_grp1 (
    .clk_i       (clk_i),
    .rst_i       (init),
    .trig_sel_i  (pattern_trigger_select[`TPO_SEL_G1_LSB +: 2]),
    .cmp_match_i (cmp_match_i),
    .enable_i    (pattern_enable_low_groups[7:4]),
    .next_data_i (next_pattern_low_groups[7:4]),
    .wr_i        (wr_pa_data),
    .wr_data_i   (wd[7:4]),
    .data_o      (grp1_data)
  );

  tpo_group u_grp2 (
    .clk_i       (clk_i),
    .rst_i       (init),
    .trig_sel_i  (pattern_trigger_select[`TPO_SEL_G2_LSB +: 2]),
    .cmp_match_i (cmp_match_i),
    .enable_i    (pattern_enable_high_groups[3:0]),
    .next_data_i (next_pattern_high_groups[3:0]),
    .wr_i        (wr_pb_data),
    .wr_data_i   (wd[3:0]),
    .data_o      (grp2_data)
  );

  // ==========================================================
  // Pin outputs
  // ==========================================================
  // One register stage so every pin leaves from a flip-flop; the pins
  // therefore trail the data registers by one cycle
  always @(posedge clk_i) begin
    if (init) begin
      port_a_out_o <= `TPO_RST_ZERO;
      port_a_oe_o  <= `TPO_RST_ZERO;
      port_b_out_o <= `TPO_RST_ZERO;
      port_b_oe_o  <= `TPO_RST_ZERO;
    end else begin
      port_a_out_o <= port_a_output_data;
      port_a_oe_o  <= port_a_direction;
      port_b_out_o <= port_b_output_data;
      port_b_oe_o  <= port_b_direction;
    end
  end

  // ==========================================================
  // Read mux and acknowledge
  // ==========================================================
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = `TPO_UNMAPPED_READ;
    if (hit(adr_i, `TPO_IDX_TRIG_SEL)) begin
      next_rdata[7:0] = pattern_trigger_select;
    end else if (hit(adr_i, `TPO_IDX_EN_HIGH)) begin
      next_rdata[7:0] = pattern_enable_high_groups;
    end else if (hit(adr_i, `TPO_IDX_EN_LOW)) begin
      next_rdata[7:0] = pattern_enable_low_groups;
    end else if (hit(adr_i, `TPO_IDX_NEXT_HIGH)) begin
      next_rdata[7:0] = next_rd_view(next_pattern_high_groups, same_high, 1'b0);
    end else if (hit(adr_i, `TPO_IDX_NEXT_LOW)) begin
      next_rdata[7:0] = next_rd_view(next_pattern_low_groups, same_low, 1'b0);
    end else if (hit(adr_i, `TPO_IDX_NEXT_HIGH_ALT)) begin
      next_rdata[7:0] = next_rd_view(next_pattern_high_groups, same_high, 1'b1);
    end else if (hit(adr_i, `TPO_IDX_NEXT_LOW_ALT)) begin
      next_rdata[7:0] = next_rd_view(next_pattern_low_groups, same_low, 1'b1);
    end else if (hit(adr_i, `TPO_IDX_PA_DIR) | hit(adr_i, `TPO_IDX_PB_DIR)) begin
      next_rdata[7:0] = `TPO_WO_READ;  // Write-only
    end else if (hit(adr_i, `TPO_IDX_PA_DATA)) begin
      next_rdata[7:0] = port_a_output_data;
    end else if (hit(adr_i, `TPO_IDX_PB_DATA)) begin
      next_rdata[7:0] = port_b_output_data;
    end
  end

  // Every access, mapped or not, answers one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `TPO_UNMAPPED_READ;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o) begin
        dat_o <= next_rdata;
      end
    end
  end

endmodule // tpo_regs

//--- verif/tpo_regs_props.sv
/*
 * Checker for the timed pattern output register block, bound to tpo_regs.
 * Assumes one clock, a synchronous active-high reset and single Wishbone cycles.
 */
// ==========================================================
// Checker
// ==========================================================
module tpo_regs_props #(
  parameter ADR_W = 18
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [3:0]       sel_i,
  input wire logic             we_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic [3:0]       cmp_match_i,
  input wire logic             hw_standby_i,
  input wire logic [7:0]       port_a_out_o,
  input wire logic [7:0]       port_a_oe_o,
  input wire logic [7:0]       port_b_out_o,
  input wire logic [7:0]       port_b_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sb_cnt;
  // Standby clears pins a few cycles late, so changes just after it are excused
  always @(posedge clk_i) begin
    if (rst_i) sb_cnt <= 4'hC;
    else if (hw_standby_i) sb_cnt <= 4'h0;
    else if (sb_cnt != 4'hC) sb_cnt <= sb_cnt + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_wr_done; ack_o && we_i && sel_i[0]; endsequence
  property p_ack_resp; s_take |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_no_spur; !(cyc_i && stb_i) |=> !ack_o; endproperty
  property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
  property p_sb_clr;
    hw_standby_i [*5] |=> (port_a_out_o | port_a_oe_o | port_b_out_o | port_b_oe_o) == 8'h00;
  endproperty
  property p_pa_cause;
    $changed(port_a_out_o) |-> $past(ack_o && we_i, 2) || $past(cmp_match_i != 4'h0, 2)
      || sb_cnt < 4'hA;
  endproperty
  property p_pb_cause;
    $changed(port_b_out_o) |-> $past(ack_o && we_i, 2) || $past(cmp_match_i != 4'h0, 2)
      || sb_cnt < 4'hA;
  endproperty
  property p_oe_cause;
    $changed({port_a_oe_o, port_b_oe_o}) |-> $past(ack_o && we_i, 2) || sb_cnt < 4'hA;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");
  a_no_spur: assert property (p_no_spur) else $error("ack without request");
  a_dat_hi: assert property (p_dat_hi) else $error("read data upper bits not zero");
  a_sb_clr: assert property (p_sb_clr) else $error("standby left pins set");
  a_pa_cause: assert property (p_pa_cause) else $error("port a pins moved uncaused");
  a_pb_cause: assert property (p_pb_cause) else $error("port b pins moved uncaused");
  a_oe_cause: assert property (p_oe_cause) else $error("enables moved uncaused");
  c_wr: cover property (s_wr_done);
endmodule // tpo_regs_props

bind tpo_regs tpo_regs_props #(.ADR_W(ADR_W)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_match_i(cmp_match_i),
  .hw_standby_i(hw_standby_i), .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
  .port_b_out_o(port_b_out_o), .port_b_oe_o(port_b_oe_o)
);

//--- verif/tpo_regs_tb.sv
/*
 * Self-checking bench for tpo_regs: Wishbone tasks and register sequences.
 * Assumes the timer/pin model drives the compare-match inputs.
 */
`include "tpo_defines.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
// ==========================================================
// Bench
// ==========================================================
module tpo_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [17:0] adr_i = 18'h00000;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        hw_standby_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [3:0]  cmp_match;
  logic [7:0]  pa_out, pa_oe, pb_out, pb_oe, pin_a;
  int          errors = 0;
  int          n_compared = 0;
  initial forever #10 clk_i = ~clk_i;
  tpo_regs dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_match_i(cmp_match), .hw_standby_i(hw_standby_i), .port_a_out_o(pa_out),
    .port_a_oe_o(pa_oe), .port_b_out_o(pb_out), .port_b_oe_o(pb_oe));
  tpo_timer_pins tmr (.clk_i(clk_i), .port_a_out_i(pa_out), .port_a_oe_i(pa_oe),
    .cmp_match_o(cmp_match), .pin_a_o(pin_a));
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One classic cycle; the answer is taken at the edge that samples ack
  task automatic wb(input logic [15:0] idx, input logic w, input logic [7:0] v,
                    input logic [3:0] s, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; sel_i <= s;
    adr_i <= {idx, 2'b00}; dat_i <= {24'h000000, v};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin errors++; print_verdict(); end
    rd = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [7:0] d;
    wb(idx, 1'b1, v, 4'hF, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] ex);
    logic [7:0] d;
    wb(idx, 1'b0, 8'h00, 4'hF, d);
    `CHK("read", ex, d)
  endtask
  initial begin
    logic [7:0] d;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TPO_IDX_PA_DIR, `TPO_WO_READ);
    rd(`TPO_IDX_NEXT_LOW, 8'h00);
    rd(`TPO_IDX_NEXT_LOW_ALT, 8'hFF);
    rd(`TPO_IDX_PA_DATA, 8'h00);
    rd(`TPO_IDX_TRIG_SEL, 8'hFF);
    rd(16'h0100, 8'h00);
    `CHK("pa_oe", 8'h00, pa_oe)
    wr(`TPO_IDX_PA_DIR, 8'hFF);
    wr(`TPO_IDX_PB_DIR, 8'h0F);
    rd(`TPO_IDX_PB_DIR, `TPO_WO_READ);
    `CHK("pa_oe", 8'hFF, pa_oe)
    `CHK("pb_oe", 8'h0F, pb_oe)
    wr(`TPO_IDX_PA_DATA, 8'h5A);
    wb(`TPO_IDX_PA_DATA, 1'b1, 8'h00, 4'hE, d);
    rd(`TPO_IDX_PA_DATA, 8'h5A);
    `CHK("pin_a", 8'h5A, pin_a)
    wr(`TPO_IDX_NEXT_LOW, 8'hC3);
    wr(`TPO_IDX_NEXT_LOW_ALT, 8'h00);
    rd(`TPO_IDX_NEXT_LOW, 8'hC3);
    rd(`TPO_IDX_NEXT_LOW_ALT, 8'hFF);
    wr(`TPO_IDX_EN_LOW, 8'h0F);
    wr(`TPO_IDX_PA_DATA, 8'h00);
    rd(`TPO_IDX_PA_DATA, 8'h0A);
    tmr.fire(0);
    rd(`TPO_IDX_PA_DATA, 8'h0A);
    tmr.fire(3);
    rd(`TPO_IDX_PA_DATA, 8'h03);
    wr(`TPO_IDX_TRIG_SEL, 8'hFC);
    rd(`TPO_IDX_NEXT_LOW, 8'hCF);
    rd(`TPO_IDX_NEXT_LOW_ALT, 8'hF3);
    wr(`TPO_IDX_NEXT_LOW_ALT, 8'h05);
    wr(`TPO_IDX_NEXT_LOW, 8'h9A);
    rd(`TPO_IDX_NEXT_LOW_ALT, 8'hF5);
    rd(`TPO_IDX_NEXT_LOW, 8'h9F);
    wr(`TPO_IDX_EN_LOW, 8'hFF);
    tmr.fire(0);
    rd(`TPO_IDX_PA_DATA, 8'h05);
    tmr.fire(3);
    rd(`TPO_IDX_PA_DATA, 8'h95);
    `CHK("pin_a", 8'h95, pin_a)
    wr(`TPO_IDX_NEXT_HIGH, 8'h06);
    wr(`TPO_IDX_EN_HIGH, 8'h0F);
    wr(`TPO_IDX_PB_DATA, 8'hFF);
    rd(`TPO_IDX_PB_DATA, 8'hF0);
    tmr.fire(3);
    rd(`TPO_IDX_PB_DATA, 8'hF6);
    `CHK("pb_out", 8'hF6, pb_out)
    @(posedge clk_i);
    hw_standby_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    hw_standby_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(`TPO_IDX_NEXT_LOW, 8'h00);
    rd(`TPO_IDX_TRIG_SEL, 8'hFF);
    rd(`TPO_IDX_PA_DATA, 8'h00);
    `CHK("pa_oe", 8'h00, pa_oe)
    print_verdict();
  end
endmodule // tpo_regs_tb

//--- verif/tpo_timer_pins.sv
/*
 * Far-side model: timer compare-match sources and the port A pins.
 * Assumes the bench calls fire() from its clocked sequence.
 */
// ==========================================================
// Timer and pins
// ==========================================================
module tpo_timer_pins (
  input  wire logic       clk_i,
  input  wire logic [7:0] port_a_out_i,
  input  wire logic [7:0] port_a_oe_i,
  output logic      [3:0] cmp_match_o,
  output logic      [7:0] pin_a_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ext_drv;
  initial cmp_match_o = 4'h0;
  initial ext_drv = 8'h55;
  // Undriven pins toggle so a stale level is never mistaken for output
  always @(posedge clk_i) ext_drv <= ~ext_drv;
  assign pin_a_o = (port_a_oe_i & port_a_out_i) | (~port_a_oe_i & ext_drv);
  // One-cycle pulse of one channel
  task automatic fire(input int ch);
    @(posedge clk_i);
    cmp_match_o <= 4'h1 << ch;
    @(posedge clk_i);
    cmp_match_o <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // tpo_timer_pins
